/* File: verif/pm_statistics_mode_control_tb_top.sv */
// Self-checking bench of the statistics engine with a polling host model.
// Assumes sample ticks every 250 cycles; checks touching a cleared set run right after a tick.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module pm_statistics_mode_control_tb_top;
	// ************************************************************
	// Signals
	// ************************************************************
	logic        REF_CLK, RST, RESTART_PIN, CMD_VALID, CMD_READY, RSP_VALID, RSP_LAST;
	logic [63:0] OBS_SAMPLE;
	logic [15:0] CMD_CODE, RSP_WORD, RSP_MIN, RSP_AVG, RSP_MAX, RSP_CUR;
	logic [7:0]  CMD_ARG, RSP_STATUS;
	logic [1:0]  RSP_INDEX, FLAG_IDX;
	logic        FLAG_RD, FLAG_CLR, FLAG_RD_VALID, LINKED_MODE;
	logic [15:0] FLAG_MIN, FLAG_AVG, FLAG_MAX, FLAG_CUR;
	int          cyc, miscompares, checks_done;

	pmsc_engine dut (.REF_CLK(REF_CLK), .RST(RST), .RESTART_PIN(RESTART_PIN), .OBS_SAMPLE(OBS_SAMPLE),
		.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_CODE(CMD_CODE), .CMD_ARG(CMD_ARG),
		.RSP_VALID(RSP_VALID), .RSP_LAST(RSP_LAST), .RSP_STATUS(RSP_STATUS), .RSP_WORD(RSP_WORD),
		.RSP_INDEX(RSP_INDEX), .RSP_MIN(RSP_MIN), .RSP_AVG(RSP_AVG), .RSP_MAX(RSP_MAX), .RSP_CUR(RSP_CUR),
		.FLAG_RD(FLAG_RD), .FLAG_IDX(FLAG_IDX), .FLAG_CLR(FLAG_CLR), .FLAG_RD_VALID(FLAG_RD_VALID),
		.FLAG_MIN(FLAG_MIN), .FLAG_AVG(FLAG_AVG), .FLAG_MAX(FLAG_MAX), .FLAG_CUR(FLAG_CUR),
		.LINKED_MODE(LINKED_MODE));

	pmsc_host_model host (.clk(REF_CLK), .cmd_valid(CMD_VALID), .cmd_ready(CMD_READY), .cmd_code(CMD_CODE),
		.cmd_arg(CMD_ARG), .rsp_valid(RSP_VALID), .rsp_last(RSP_LAST), .rsp_status(RSP_STATUS),
		.rsp_word(RSP_WORD), .rsp_index(RSP_INDEX), .rsp_min(RSP_MIN), .rsp_avg(RSP_AVG),
		.rsp_max(RSP_MAX), .rsp_cur(RSP_CUR));

	// Clock and cycle count, with a ceiling against hangs
	initial begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) cyc <= 0;
		else cyc <= cyc + 1;
	end
	always @(posedge REF_CLK) begin
		if (cyc > 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ************************************************************
	// Helpers
	// ************************************************************
	// Two sample values per observable; their gap is below the averaging step
	function automatic logic [15:0] v1(input int k);
		return 16'h0100 + 16'h0040 * 16'(k);
	endfunction : v1
	function automatic logic [15:0] v2(input int k);
		return v1(k) + 16'h0005;
	endfunction : v2
	task automatic obs_set(input bit second);
		for (int k = 0; k < 4; k++) OBS_SAMPLE[16*k +: 16] = second ? v2(k) : v1(k);
	endtask : obs_set
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge REF_CLK);
	endtask : wait_cyc
	// Park just after a sample tick, leaving a long tick-free stretch
	task automatic sync_tick();
		while (cyc % 250 != 10) @(negedge REF_CLK);
	endtask : sync_tick
	task automatic flag_pulse();
		FLAG_CLR = 1'b1;
		wait_cyc(1);
		FLAG_CLR = 1'b0;
	endtask : flag_pulse
	// Judge the last command-path read: filled with v1 then v2, or empty
	task automatic chk_cmd(input bit full);
		for (int k = 0; k < 4; k++) begin
			`CHK(host.vl[k], 1'b1)
			`CHK(host.ix[k], k[1:0])
			`CHK(host.la[k], (k == 3))
			`CHK(host.mn[k], full ? v1(k) : pmsc_pkg::MIN_RESET)
			`CHK(host.mx[k], full ? v2(k) : pmsc_pkg::MAX_RESET)
			if (full) begin
				`CHK(host.av[k], v1(k))
				`CHK(host.cu[k], v2(k))
			end
		end
	endtask : chk_cmd
	// Read and judge every observable on the flag path
	task automatic chk_flag(input bit full);
		FLAG_RD = 1'b1; // Held high over back-to-back reads
		for (int k = 0; k < 4; k++) begin
			FLAG_IDX = k[1:0];
			wait_cyc(1);
			`CHK(FLAG_RD_VALID, 1'b1)
			`CHK(FLAG_MIN, full ? v1(k) : pmsc_pkg::MIN_RESET)
			`CHK(FLAG_MAX, full ? v2(k) : pmsc_pkg::MAX_RESET)
			if (full) begin
				`CHK(FLAG_AVG, v1(k))
				`CHK(FLAG_CUR, v2(k))
			end
		end
		FLAG_RD = 1'b0;
		FLAG_IDX = 2'h0;
	endtask : chk_flag

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		`CHK(LINKED_MODE, 1'b0)
		`CHK(CMD_READY, 1'b1)
	endtask : t_reset
	// Feature queries and an unknown code, back to back
	task automatic t_query();
		host.cmd(pmsc_pkg::CMD_FEAT_QUERY, 8'h00);
		`CHK(host.ok, 1'b1)
		`CHK(host.wd, pmsc_pkg::FEAT_WORD)
		host.cmd(pmsc_pkg::CMD_PM_FEATURES, 8'h00);
		`CHK(host.st, pmsc_pkg::ST_OK)
		`CHK(host.wd, pmsc_pkg::PM_FEAT_WORD)
		host.cmd(16'h0333, 8'h00);
		`CHK(host.st, pmsc_pkg::ST_BAD_CMD)
	endtask : t_query
	// First results are discarded, both sets restarted, then both read in full
	task automatic t_read();
		host.read_all();
		obs_set(1'b0);
		FLAG_CLR = 1'b1;
		host.cmd(pmsc_pkg::CMD_PM_CLEAR, 8'h00);
		FLAG_CLR = 1'b0;
		`CHK(host.st, pmsc_pkg::ST_OK)
		wait_cyc(250);
		obs_set(1'b1);
		wait_cyc(260);
		host.read_all();
		chk_cmd(1'b1);
		chk_flag(1'b1);
	endtask : t_read
	// Independent mode: the command clear leaves the flag set untouched, then the flag clear empties it
	task automatic t_indep();
		sync_tick();
		host.cmd(pmsc_pkg::CMD_PM_CLEAR, 8'h00);
		host.read_all();
		chk_cmd(1'b0);
		chk_flag(1'b1);
		flag_pulse();
		chk_flag(1'b0);
	endtask : t_indep
	// Linked mode: change clears, one shared set, either clear empties it
	task automatic t_linked();
		sync_tick();
		obs_set(1'b0);
		host.cmd(pmsc_pkg::CMD_PM_MODE, 8'h01);
		`CHK(host.st, pmsc_pkg::ST_OK)
		`CHK(LINKED_MODE, 1'b1)
		host.read_all();
		chk_cmd(1'b0);
		chk_flag(1'b0);
		wait_cyc(250);
		obs_set(1'b1);
		wait_cyc(260);
		host.read_all();
		chk_cmd(1'b1);
		chk_flag(1'b1);
		sync_tick();
		flag_pulse();
		host.read_all();
		chk_cmd(1'b0);
		wait_cyc(260);
		sync_tick();
		host.cmd(pmsc_pkg::CMD_PM_CLEAR, 8'h00);
		chk_flag(1'b0);
	endtask : t_linked
	// Restart from linked mode falls back to independent and empties both sets
	task automatic t_restart();
		wait_cyc(260);
		sync_tick();
		`CHK(LINKED_MODE, 1'b1)
		RESTART_PIN = 1'b1;
		wait_cyc(6);
		RESTART_PIN = 1'b0;
		wait_cyc(6);
		`CHK(LINKED_MODE, 1'b0)
		host.read_all();
		chk_cmd(1'b0);
		chk_flag(1'b0);
	endtask : t_restart

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// Main sequence
	initial begin
		miscompares = 0;
		checks_done = 0;
		RST = 1'b1;
		RESTART_PIN = 1'b0;
		OBS_SAMPLE = 64'h0;
		FLAG_RD = 1'b0;
		FLAG_IDX = 2'h0;
		FLAG_CLR = 1'b0;
		wait_cyc(20);
		RST = 1'b0;
		wait_cyc(1);
		t_reset();
		t_query();
		t_read();
		t_indep();
		t_linked();
		t_restart();
		wrap_up();
	end

endmodule : pm_statistics_mode_control_tb_top

`default_nettype wire

/* File: verif/pmsc_host_model.sv */
// Host controller model that polls the statistics engine over the command-message channel.
// Assumes tasks are entered just after a falling edge of clk and that the engine answers as its notes say.
`timescale 1ns/1ps
`default_nettype none

module pmsc_host_model (
	// Clock
	input  wire logic                        clk,
	// Request
	output var  logic                        cmd_valid,
	input  wire logic                        cmd_ready,
	output var  logic [15:0]                 cmd_code,
	output var  logic [7:0]                  cmd_arg,
	// Answer
	input  wire logic                        rsp_valid,
	input  wire logic                        rsp_last,
	input  wire logic [7:0]                  rsp_status,
	input  wire logic [15:0]                 rsp_word,
	input  wire logic [pmsc_pkg::IDX_W-1:0] rsp_index,
	input  wire logic [15:0]                 rsp_min,
	input  wire logic [15:0]                 rsp_avg,
	input  wire logic [15:0]                 rsp_max,
	input  wire logic [15:0]                 rsp_cur
);
	// ************************************************************
	// Captured answers
	// ************************************************************
	logic                        ok;
	logic [7:0]                  st;
	logic [15:0]                 wd;
	logic [pmsc_pkg::IDX_W-1:0] ix [4];
	logic                        vl [4];
	logic                        la [4];
	logic [15:0]                 mn [4];
	logic [15:0]                 av [4];
	logic [15:0]                 mx [4];
	logic [15:0]                 cu [4];

	// Idle request lines
	initial begin
		cmd_valid = 1'b0;
		cmd_code  = 16'h0000;
		cmd_arg   = 8'h00;
	end

	// One command, held until the edge that takes it; one idle edge follows before returning
	task automatic cmd(input logic [15:0] code, input logic [7:0] arg);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_code  = code;
		cmd_arg   = arg;
		@(posedge clk);
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code  = ~code; // Released lines do not keep the last value
		cmd_arg   = ~arg;
		ok        = rsp_valid;
		st        = rsp_status;
		wd        = rsp_word;
		@(negedge clk); // Valid stays low over one edge; a read's first word is out by now
	endtask : cmd

	// Polled read of every observable, one answer word per cycle
	task automatic read_all();
		cmd(pmsc_pkg::CMD_PM_READ, 8'h00);
		for (int k = 0; k < 4; k++) begin
			if (k > 0) begin
				@(negedge clk);
			end
			vl[k] = rsp_valid;
			la[k] = rsp_last;
			ix[k] = rsp_index;
			mn[k] = rsp_min;
			av[k] = rsp_avg;
			mx[k] = rsp_max;
			cu[k] = rsp_cur;
		end
		@(negedge clk);
	endtask : read_all

endmodule : pmsc_host_model

`default_nettype wire

/* File: verilog/pmsc_engine.sv */
// Performance-monitoring statistics engine with a polled command channel and a flag-based monitor path.
// Assumes command requests and observable samples come from logic on REF_CLK; restart arrives on a pin.
//
// Contract
// - Feature-query commands are answered with the supported feature lists.
// - One read command returns every observable; statistics come only by host polling.
// - The command path raises no alarm indications; flags belong to the monitor path.
// - Both paths may run together over overlapping observables.
// - After reset the mode is independent.
// - A mode command selects independent or linked collection at runtime.
// - Every module restart returns the mode to independent.
// - Any mode change clears every statistics result; the current value cur_v is left as it was.
// - Independent mode keeps two data sets; clearing one leaves the other untouched.
// - Linked mode keeps one shared data set returned through both paths.
// - Linked mode clears the shared set on either path's clear.
`timescale 1ns/1ps
`default_nettype none

module pmsc_engine (
	// Clock and reset
	input  wire logic                                     REF_CLK,
	input  wire logic                                     RST,
	// Module restart pin, high requests a restart
	input  wire logic                                     RESTART_PIN,
	// Observable samples, observable i in bits [16*i +: 16]
	input  wire logic [pmsc_pkg::NUM_OBS*pmsc_pkg::OBS_W-1:0] OBS_SAMPLE,
	// Command-message channel request
	input  wire logic                                     CMD_VALID,
	output logic                                          CMD_READY,
	input  wire logic [15:0]                              CMD_CODE,
	input  wire logic [7:0]                               CMD_ARG,
	// Command-message channel answer
	output logic                                          RSP_VALID,
	output logic                                          RSP_LAST,
	output logic [7:0]                                    RSP_STATUS,
	output logic [15:0]                                   RSP_WORD,
	output logic [pmsc_pkg::IDX_W-1:0]                    RSP_INDEX,
	output logic [15:0]                                   RSP_MIN,
	output logic [15:0]                                   RSP_AVG,
	output logic [15:0]                                   RSP_MAX,
	output logic [15:0]                                   RSP_CUR,
	// Flag-based monitor path
	input  wire logic                                     FLAG_RD,
	input  wire logic [pmsc_pkg::IDX_W-1:0]               FLAG_IDX,
	input  wire logic                                     FLAG_CLR,
	output logic                                          FLAG_RD_VALID,
	output logic [15:0]                                   FLAG_MIN,
	output logic [15:0]                                   FLAG_AVG,
	output logic [15:0]                                   FLAG_MAX,
	output logic [15:0]                                   FLAG_CUR,
	// Current mode
	output logic                                          LINKED_MODE
);

	localparam int BUS_W = pmsc_pkg::NUM_OBS * pmsc_pkg::OBS_W;

	typedef enum logic {ST_IDLE, ST_STREAM} pmsc_state_t;

	// ************************************************************
	// Helpers
	// ************************************************************
	// Pick one observable's value out of a flattened bus
	function automatic logic [15:0] pick(input logic [BUS_W-1:0] bus, input logic [pmsc_pkg::IDX_W-1:0] idx);
		pick = bus[idx*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W];
	endfunction : pick

	pmsc_state_t               state_r;
	pmsc_state_t               state_nxt;
	logic [pmsc_pkg::IDX_W-1:0] idx_r;
	logic [pmsc_pkg::TICK_W-1:0] tick_cnt_r;
	logic                      mode_r;
	logic                      mode_nxt;
	logic                      restart_lvl;
	logic                      restart_q_r;
	logic                      restart_evt;
	logic                      tick;
	logic                      cmd_take;
	logic                      is_mode;
	logic                      is_read;
	logic                      is_clear;
	logic                      is_feat;
	logic                      is_pmfeat;
	logic                      mode_change;
	logic                      clear_all;
	logic                      clr_a;
	logic                      clr_b;
	logic [BUS_W-1:0]          min_a;
	logic [BUS_W-1:0]          avg_a;
	logic [BUS_W-1:0]          max_a;
	logic [BUS_W-1:0]          cur_a;
	logic [BUS_W-1:0]          min_b;
	logic [BUS_W-1:0]          avg_b;
	logic [BUS_W-1:0]          max_b;
	logic [BUS_W-1:0]          cur_b;
	logic [BUS_W-1:0]          fmin_bus;
	logic [BUS_W-1:0]          favg_bus;
	logic [BUS_W-1:0]          fmax_bus;
	logic [BUS_W-1:0]          fcur_bus;

	// ************************************************************
	// Restart pin and sample tick
	// ************************************************************
	pmsc_sync u_restart_sync (
		.clk   (REF_CLK),
		.rst   (RST),
		.pin   (RESTART_PIN),
		.level (restart_lvl)
	);

	// Rising edge of the agreed restart level
	assign restart_evt = restart_lvl & ~restart_q_r;
	assign tick        = (tick_cnt_r == pmsc_pkg::TICK_LAST);

	// Fixed sample divider and restart edge memory
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			tick_cnt_r  <= '0;
			restart_q_r <= 1'b0;
		end else begin
			tick_cnt_r  <= tick ? '0 : tick_cnt_r + 1'b1;
			restart_q_r <= restart_lvl;
		end
	end

	// ************************************************************
	// Command decode
	// ************************************************************
	assign CMD_READY = (state_r == ST_IDLE);
	assign cmd_take  = CMD_VALID & CMD_READY;
	assign is_mode   = (CMD_CODE == pmsc_pkg::CMD_PM_MODE);
	assign is_read   = (CMD_CODE == pmsc_pkg::CMD_PM_READ);
	assign is_clear  = (CMD_CODE == pmsc_pkg::CMD_PM_CLEAR);
	assign is_feat   = (CMD_CODE == pmsc_pkg::CMD_FEAT_QUERY);
	assign is_pmfeat = (CMD_CODE == pmsc_pkg::CMD_PM_FEATURES);

	// ************************************************************
	// Mode selection and clearing
	// ************************************************************
	// Restart forces independent; a mode command only counts when it changes the mode
	assign mode_nxt    = restart_evt ? pmsc_pkg::MODE_INDEP :
	                     (cmd_take & is_mode) ? CMD_ARG[pmsc_pkg::MODE_ARG_BIT] : mode_r;
	assign mode_change = (mode_nxt != mode_r);
	assign clear_all   = mode_change | restart_evt;
	// Set A serves commands, and both paths when linked; set B serves flags when independent
	assign clr_a = clear_all | (cmd_take & is_clear) | (mode_r & FLAG_CLR);
	assign clr_b = clear_all | (~mode_r & FLAG_CLR);

	// Mode register, independent out of reset
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			mode_r <= pmsc_pkg::MODE_INDEP;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign LINKED_MODE = mode_r;

	// ************************************************************
	// Two statistics sets per observable
	// ************************************************************
	// Both sets sample every observable, so the paths run side by side
	for (genvar g = 0; g < pmsc_pkg::NUM_OBS; g++) begin : g_obs
		pmsc_stats u_set_a (
			.clk    (REF_CLK),
			.rst    (RST),
			.tick   (tick),
			.clr    (clr_a),
			.sample (OBS_SAMPLE[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W]),
			.min_v  (min_a[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W]),
			.avg_v  (avg_a[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W]),
			.max_v  (max_a[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W]),
			.cur_v  (cur_a[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W])
		);
		pmsc_stats u_set_b (
			.clk    (REF_CLK),
			.rst    (RST),
			.tick   (tick),
			.clr    (clr_b),
			.sample (OBS_SAMPLE[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W]),
			.min_v  (min_b[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W]),
			.avg_v  (avg_b[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W]),
			.max_v  (max_b[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W]),
			.cur_v  (cur_b[g*pmsc_pkg::OBS_W +: pmsc_pkg::OBS_W])
		);
	end

	// Flag path reads the shared set when linked
	assign fmin_bus = mode_r ? min_a : min_b;
	assign favg_bus = mode_r ? avg_a : avg_b;
	assign fmax_bus = mode_r ? max_a : max_b;
	assign fcur_bus = mode_r ? cur_a : cur_b;

	// ************************************************************
	// Command answer state machine
	// ************************************************************
	// A read streams one answer per observable, back to back
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (cmd_take && is_read) begin
					state_nxt = ST_STREAM;
				end
			end
			ST_STREAM: begin
				if (idx_r == pmsc_pkg::IDX_W'(pmsc_pkg::NUM_OBS - 1)) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Answer registers; statistics leave only on a poll, never as an alarm
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state_r    <= ST_IDLE;
			idx_r      <= '0;
			RSP_VALID  <= 1'b0;
			RSP_LAST   <= 1'b0;
			RSP_STATUS <= 8'h00;
			RSP_WORD   <= 16'h0000;
			RSP_INDEX  <= '0;
			RSP_MIN    <= 16'h0000;
			RSP_AVG    <= 16'h0000;
			RSP_MAX    <= 16'h0000;
			RSP_CUR    <= 16'h0000;
		end else begin
			state_r   <= state_nxt;
			RSP_VALID <= 1'b0;
			RSP_LAST  <= 1'b0;
			if (state_r == ST_STREAM) begin
				RSP_VALID  <= 1'b1;
				RSP_LAST   <= (idx_r == pmsc_pkg::IDX_W'(pmsc_pkg::NUM_OBS - 1));
				RSP_STATUS <= pmsc_pkg::ST_OK;
				RSP_INDEX  <= idx_r;
				RSP_MIN    <= pick(min_a, idx_r);
				RSP_AVG    <= pick(avg_a, idx_r);
				RSP_MAX    <= pick(max_a, idx_r);
				RSP_CUR    <= pick(cur_a, idx_r);
				idx_r      <= idx_r + 1'b1;
			end else if (cmd_take && !is_read) begin
				RSP_VALID  <= 1'b1;
				RSP_LAST   <= 1'b1;
				RSP_STATUS <= (is_mode | is_clear | is_feat | is_pmfeat) ? pmsc_pkg::ST_OK : pmsc_pkg::ST_BAD_CMD;
				RSP_WORD   <= is_feat ? pmsc_pkg::FEAT_WORD :
				              is_pmfeat ? pmsc_pkg::PM_FEAT_WORD : 16'h0000;
				idx_r      <= '0;
			end
		end
	end

	// ************************************************************
	// Flag path read port
	// ************************************************************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			FLAG_RD_VALID <= 1'b0;
			FLAG_MIN      <= 16'h0000;
			FLAG_AVG      <= 16'h0000;
			FLAG_MAX      <= 16'h0000;
			FLAG_CUR      <= 16'h0000;
		end else begin
			FLAG_RD_VALID <= FLAG_RD;
			if (FLAG_RD) begin
				FLAG_MIN <= pick(fmin_bus, FLAG_IDX);
				FLAG_AVG <= pick(favg_bus, FLAG_IDX);
				FLAG_MAX <= pick(fmax_bus, FLAG_IDX);
				FLAG_CUR <= pick(fcur_bus, FLAG_IDX);
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	a_restart_to_indep: assert property (restart_evt |=> !LINKED_MODE)
		else $error("Mode not independent after restart");
	a_mode_change_clears: assert property ($changed(mode_r) |-> $past(clr_a) && $past(clr_b))
		else $error("Mode changed without clearing both sets");
	a_indep_flag_clear: assert property (FLAG_CLR && !mode_r && !clear_all && !(cmd_take && is_clear) |-> !clr_a)
		else $error("Flag clear touched the command set");
	a_linked_flag_clear: assert property (FLAG_CLR && mode_r |-> clr_a)
		else $error("Flag clear missed the shared set");
	a_linked_same_data: assert property (FLAG_RD && mode_r |=> FLAG_AVG == pick($past(avg_a), $past(FLAG_IDX)))
		else $error("Linked flag read differs from shared set");
	a_read_streams_all: assert property (cmd_take && is_read |=> ##1 RSP_VALID [*4] ##0 RSP_LAST)
		else $error("Read did not return every observable");
	a_feature_answer: assert property (cmd_take && is_pmfeat |=> RSP_VALID && RSP_WORD == pmsc_pkg::PM_FEAT_WORD)
		else $error("Feature query answered wrongly");
	a_mode_select: assert property (cmd_take && is_mode && !restart_evt |=> LINKED_MODE == $past(CMD_ARG[0]))
		else $error("Mode command not applied");
	a_tick_spacing: assert property (tick |=> !tick [*8])
		else $error("Sample tick too frequent");

endmodule : pmsc_engine

`default_nettype wire

/* File: verilog/pmsc_pkg.sv */
// Constants shared by the statistics engine: command codes, status codes, sizes and sample timing.
// Assumes one 25 MHz clock; no software-visible registers exist.
`default_nettype none

package pmsc_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_OBS  = 4;                 // Observables with statistics
	localparam int OBS_W    = 16;                // Width of one observable value
	localparam int IDX_W    = 2;                 // Width of an observable index
	localparam int AVG_SHIFT = 3;                // Averaging weight of a new sample, 1/8

	// ************************************************************
	// Command codes
	// ************************************************************
	localparam logic [15:0] CMD_FEAT_QUERY  = 16'h0042; // General feature list
	localparam logic [15:0] CMD_PM_MODE     = 16'h0200; // Select independent or linked mode
	localparam logic [15:0] CMD_PM_FEATURES = 16'h0201; // Monitoring feature list
	localparam logic [15:0] CMD_PM_READ     = 16'h0210; // Read all observables
	localparam logic [15:0] CMD_PM_CLEAR    = 16'h0211; // Clear command-path statistics

	// ************************************************************
	// Answers
	// ************************************************************
	localparam logic [7:0]  ST_OK       = 8'h01;
	localparam logic [7:0]  ST_BAD_CMD  = 8'h02;
	localparam logic [15:0] FEAT_WORD   = 16'h0001; // Monitoring supported
	localparam logic [15:0] PM_FEAT_WORD = 16'h000f; // One bit per observable with statistics
	localparam logic        MODE_INDEP  = 1'b0;
	localparam logic        MODE_LINKED = 1'b1;
	localparam int          MODE_ARG_BIT = 0;      // Argument bit that carries the mode

	// ************************************************************
	// Sample tick
	// ************************************************************
	localparam int CLK_MHZ        = 25;
	localparam int TICK_PERIOD_US = 10;            // Time between two statistics samples
	localparam int TICK_CYC       = TICK_PERIOD_US * CLK_MHZ;
	localparam int TICK_W         = 8;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

	localparam logic [15:0] MIN_RESET = 16'hffff;  // Empty minimum
	localparam logic [15:0] MAX_RESET = 16'h0000;  // Empty maximum

endpackage : pmsc_pkg

`default_nettype wire

/* File: verilog/pmsc_stats.sv */
// One statistics set for one observable: minimum, running average, maximum and current value.
// Assumes tick is a one-cycle pulse and clr a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pmsc_stats (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control
	input  wire logic        tick,
	input  wire logic        clr,
	input  wire logic [15:0] sample,
	// Results
	output var  logic [15:0] min_v,
	output var  logic [15:0] avg_v,
	output var  logic [15:0] max_v,
	output var  logic [15:0] cur_v
);

	logic               have_r;
	logic signed [16:0] diff;
	logic signed [16:0] avg_sum;
	logic        [15:0] avg_nxt;

	// Running average: first sample loads, later ones move it by a fraction
	assign diff    = $signed({1'b0, sample}) - $signed({1'b0, avg_v});
	assign avg_sum = $signed({1'b0, avg_v}) + (diff >>> pmsc_pkg::AVG_SHIFT);
	assign avg_nxt = have_r ? avg_sum[15:0] : sample;

	// ************************************************************
	// Accumulators; a clear wins over a sample in the same cycle
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			have_r <= 1'b0;
			min_v  <= pmsc_pkg::MIN_RESET;
			max_v  <= pmsc_pkg::MAX_RESET;
			avg_v  <= 16'h0000;
			cur_v  <= 16'h0000;
		end else if (clr) begin
			have_r <= 1'b0;
			min_v  <= pmsc_pkg::MIN_RESET;
			max_v  <= pmsc_pkg::MAX_RESET;
			avg_v  <= 16'h0000;
		end else if (tick) begin
			have_r <= 1'b1;
			cur_v  <= sample;
			avg_v  <= avg_nxt;
			if (sample < min_v) begin
				min_v <= sample;
			end
			if (sample > max_v) begin
				max_v <= sample;
			end
		end
	end

endmodule : pmsc_stats

`default_nettype wire

/* File: verilog/pmsc_sync.sv */
// Three-stage synchroniser for a pin level.
// Assumes the pin is asynchronous to clk; the output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pmsc_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pin and result
	input  wire logic pin,
	output var  logic level
);

	logic s1_r;
	logic s2_r;
	logic s3_r;

	// ************************************************************
	// Synchroniser chain and agreement filter
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r  <= 1'b0;
			s2_r  <= 1'b0;
			s3_r  <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level <= s3_r;
			end
		end
	end

endmodule : pmsc_sync

`default_nettype wire
